// ===== hw/secl_latches.sv
// Shared-enable configuration latches with an APB status and control port
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Function
// - BIST latch open passes bits to BIST
// - Low bit runs BIST, high bit normal
// - BIST latch holds bits after closing
// - Reset clears closed BIST latch, BIST off
// - Open RX latch: bit 0 drives power
// - Closing RX latch captures bit 0
// - Reset clears closed RX latch, RX off
// - Output latch passes then captures independently
// - High enables driver; reset disables both
// - Reset sampled; outputs settle within 16
module secl_latches #(
   parameter int SETTLE_CYCLES = secl_pkg::SECL_SETTLE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic device_reset_n,
   input secl_pkg::secl_pins_t pins_in,
   output secl_pkg::secl_cfg_t cfg_out,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import secl_pkg::*;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   secl_pins_t meta_q;
   secl_pins_t sync_q;

   // Two-stage capture of the asynchronous pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= pins_in;
         sync_q <= meta_q;
      end
   end

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   // Ready rises SETTLE_CYCLES - 1 edges after the first edge that sees reset
   // released; that first edge only moves the tracker out of IN_RESET
   localparam int LAST_COUNT = SETTLE_CYCLES - 2;
   // Counter stops in READY, so it only has to hold the last settle count
   localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

   logic [1:0] bist_q, bist_d;
   logic rxpwr_q, rxpwr_d;
   logic [1:0] oe_q, oe_d;
   logic clear_q, clear_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   secl_state_t state_q, state_d;
   logic [31:0] prdata_q, prdata_d;
   logic dev_rst;
   logic sel_status;
   logic sel_ctrl;
   logic addr_ok;
   logic wr_ctrl;
   logic rd_setup;

   // ------------------------------------------------------------
   // Reset sources and bus decode
   // ------------------------------------------------------------
   // Pin reset and the register clear pulse act alike on every latch
   assign dev_rst = !device_reset_n || clear_q;
   // Word decode ignores the byte-lane bits of the address
   assign sel_status = ((paddr & SECL_ADDR_MASK) == SECL_STATUS_OFS);
   assign sel_ctrl = ((paddr & SECL_ADDR_MASK) == SECL_CTRL_OFS);
   assign addr_ok = sel_status || sel_ctrl;
   // Writes act at the access edge, reads are staged at the setup edge
   assign wr_ctrl = psel && penable && pwrite && sel_ctrl;
   assign rd_setup = psel && !penable && !pwrite;

   // ------------------------------------------------------------
   // Configuration latches
   // ------------------------------------------------------------
   // Next latch values; an open BIST or RX latch keeps following the pins
   // through reset, while the serial output latch always yields to reset
   always_comb begin
      bist_d = bist_q;
      rxpwr_d = rxpwr_q;
      oe_d = oe_q;
      // BIST latch: transparent while open, cleared by reset when closed
      if (sync_q.bist_latch_open) begin
         bist_d = sync_q.shared_enable_bits;
      end else if (dev_rst) begin
         bist_d = SECL_BIST_OFF;
      end else begin
         bist_d = bist_q;
      end
      // Receive power latch on bit 0
      if (sync_q.rx_power_latch_open) begin
         rxpwr_d = sync_q.shared_enable_bits[SECL_RX_BIT];
      end else if (dev_rst) begin
         rxpwr_d = SECL_RXPWR_OFF;
      end else begin
         rxpwr_d = rxpwr_q;
      end
      // Serial output latch, reset wins regardless of its enable
      if (dev_rst) begin
         oe_d = SECL_OE_OFF;
      end else if (sync_q.serial_out_latch_open) begin
         oe_d = sync_q.shared_enable_bits;
      end
   end

   // Latch registers; power-up leaves BIST off, RX and drivers down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bist_q <= SECL_BIST_OFF;
         rxpwr_q <= SECL_RXPWR_OFF;
         oe_q <= SECL_OE_OFF;
      end else begin
         bist_q <= bist_d;
         rxpwr_q <= rxpwr_d;
         oe_q <= oe_d;
      end
   end

   // ------------------------------------------------------------
   // Settle tracker
   // ------------------------------------------------------------
   // Next tracker values; any reset restarts the count from zero
   always_comb begin
      cnt_d = cnt_q;
      state_d = state_q;
      case (state_q)
         SECL_IN_RESET: begin
            cnt_d = '0;
            if (!dev_rst) begin
               state_d = SECL_SETTLE;
            end
         end
         SECL_SETTLE: begin
            cnt_d = cnt_q + CNT_W'(1);
            if (dev_rst) begin
               state_d = SECL_IN_RESET;
            end else if (cnt_q == CNT_W'(LAST_COUNT)) begin
               state_d = SECL_READY;
            end
         end
         SECL_READY: begin
            if (dev_rst) begin
               state_d = SECL_IN_RESET;
            end
         end
         default: begin
            state_d = SECL_IN_RESET;
         end
      endcase
   end

   // Tracker registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         state_q <= SECL_IN_RESET;
      end else begin
         cnt_q <= cnt_d;
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   // Clear pulse lasts one cycle; read data is staged at the setup edge
   // so that it stands through the whole access phase
   always_comb begin
      clear_d = wr_ctrl && pwdata[SECL_CTRL_CLEAR];
      prdata_d = prdata_q;
      if (rd_setup) begin
         prdata_d = SECL_ZERO_WORD;
         if (sel_status) begin
            prdata_d[SECL_ST_BIST_LSB +: 2] = bist_q;
            prdata_d[SECL_ST_RXPWR] = rxpwr_q;
            prdata_d[SECL_ST_OE_LSB +: 2] = oe_q;
            prdata_d[SECL_ST_READY] = (state_q == SECL_READY);
            prdata_d[SECL_ST_BITS_LSB +: 2] = sync_q.shared_enable_bits;
            prdata_d[SECL_ST_BIST_OPEN] = sync_q.bist_latch_open;
            prdata_d[SECL_ST_RX_OPEN] = sync_q.rx_power_latch_open;
            prdata_d[SECL_ST_OE_OPEN] = sync_q.serial_out_latch_open;
         end
      end
   end

   // Register port registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clear_q <= 1'b0;
         prdata_q <= SECL_ZERO_WORD;
      end else begin
         clear_q <= clear_d;
         prdata_q <= prdata_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Low bit in the BIST latch selects the self-test sequence
   assign cfg_out.tx_bist_active = !bist_q[SECL_TX_BIT];
   assign cfg_out.rx_bist_active = !bist_q[SECL_RX_BIT];
   assign cfg_out.rx_power_en = rxpwr_q;
   assign cfg_out.serial_out_en = oe_q;
   assign cfg_out.outputs_ready = (state_q == SECL_READY);

   // APB answers with no wait states
   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
endmodule : secl_latches

// ===== shared/secl_pkg.sv
// Package for the shared-enable configuration latch block
package secl_pkg;
   // ------------------------------------------------------------
   // Register map (APB byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] SECL_STATUS_OFS = 8'h00;
   localparam logic [7:0] SECL_CTRL_OFS = 8'h04;
   localparam logic [7:0] SECL_ADDR_MASK = 8'hFC;

   // STATUS field positions
   localparam int SECL_ST_BIST_LSB = 0;
   localparam int SECL_ST_RXPWR = 2;
   localparam int SECL_ST_OE_LSB = 3;
   localparam int SECL_ST_READY = 5;
   localparam int SECL_ST_BITS_LSB = 6;
   localparam int SECL_ST_BIST_OPEN = 8;
   localparam int SECL_ST_RX_OPEN = 9;
   localparam int SECL_ST_OE_OPEN = 10;

   // CTRL field positions
   localparam int SECL_CTRL_CLEAR = 0;

   // ------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------
   localparam logic [1:0] SECL_BIST_OFF = 2'h3;  // High bits mean normal data path
   localparam logic SECL_RXPWR_OFF = 1'b0;
   localparam logic [1:0] SECL_OE_OFF = 2'h0;
   localparam int SECL_SETTLE_CYCLES = 16;
   localparam logic [31:0] SECL_ZERO_WORD = 32'h0000_0000;

   // Bit usage of the shared enable pair
   localparam int SECL_RX_BIT = 0;
   localparam int SECL_TX_BIT = 1;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic tx_bist_active;
      logic rx_bist_active;
      logic rx_power_en;
      logic [1:0] serial_out_en;
      logic outputs_ready;
   } secl_cfg_t;

   typedef struct packed {
      logic bist_latch_open;
      logic rx_power_latch_open;
      logic serial_out_latch_open;
      logic [1:0] shared_enable_bits;
   } secl_pins_t;

   typedef enum logic [1:0] {
      SECL_IN_RESET,
      SECL_SETTLE,
      SECL_READY
   } secl_state_t;
endpackage : secl_pkg

// ===== tb/secl_properties.sv
// Checker for the shared-enable configuration latches
`timescale 1ns/1ps
module secl_properties import secl_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic device_reset_n,
   input secl_pkg::secl_pins_t pins_in,
   input secl_pkg::secl_cfg_t cfg_out,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Quiet means no device reset and no register write that could clear a latch
   wire logic quiet = device_reset_n && !(psel && penable && pwrite);
   wire logic bo = pins_in.bist_latch_open;
   wire logic ro = pins_in.rx_power_latch_open;
   wire logic oo = pins_in.serial_out_latch_open;
   wire logic [1:0] bits = pins_in.shared_enable_bits;
   wire logic [1:0] bist = {cfg_out.tx_bist_active, cfg_out.rx_bist_active};
   sequence s_open(o);
      (o && quiet && $stable(pins_in)) [*4];
   endsequence
   sequence s_shut(o);
      (!o && quiet) [*5];
   endsequence
   a_bist_passes: assert property (s_open(bo) |-> bist == ~bits)
      else $error("bist latch not following bits");
   a_bist_holds: assert property (s_shut(bo) |-> $stable(bist))
      else $error("bist latch moved while closed");
   a_rx_passes: assert property (s_open(ro) |-> cfg_out.rx_power_en == bits[0])
      else $error("rx power not following bit 0");
   a_rx_holds: assert property (s_shut(ro) |-> $stable(cfg_out.rx_power_en))
      else $error("rx power moved while closed");
   a_out_passes: assert property (s_open(oo) |-> cfg_out.serial_out_en == bits)
      else $error("output enables not following bits");
   a_out_holds: assert property (s_shut(oo) |-> $stable(cfg_out.serial_out_en))
      else $error("output enables moved while closed");
   a_reset_clears: assert property ((!device_reset_n && !bo && !ro) [*4] |->
      {bist, cfg_out.rx_power_en, cfg_out.serial_out_en} == 5'h0) else $error("reset left a latch set");
   a_ready_drops: assert property (!device_reset_n [*3] |-> !cfg_out.outputs_ready)
      else $error("ready high during device reset");
   a_ready_rises: assert property ($rose(device_reset_n) |-> ##[1:17] cfg_out.outputs_ready)
      else $error("ready late after device reset");
endmodule : secl_properties
bind secl_latches secl_properties u_props (.pclk(pclk), .presetn(presetn),
   .device_reset_n(device_reset_n), .pins_in(pins_in), .cfg_out(cfg_out), .psel(psel),
   .penable(penable), .pwrite(pwrite));

// ===== tb/secl_host_model.sv
// Host logic that drives the latch-open and shared enable pins
`timescale 1ns/1ps
module secl_host_model import secl_pkg::*; (
   input wire logic pclk,
   input secl_pkg::secl_pins_t want,
   output secl_pkg::secl_pins_t pins
);
   // Pins change just after an edge; bits are never moved in the same step as a close
   always @(posedge pclk) pins <= want;
endmodule : secl_host_model

// ===== tb/testbench.sv
// Self-checking bench for the shared-enable configuration latches
`timescale 1ns/1ps
module testbench;
   import secl_pkg::*;
   logic pclk, presetn, device_reset_n, psel, penable, pwrite, pready, pslverr, er, es;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] eb, eo;
   secl_pins_t want, pins_in;
   secl_cfg_t cfg_out, cfg_seen;
   int errors = 0, cmp_count = 0;
   logic [4:0] rows [9] = '{5'h1D, 5'h01, 5'h02, 5'h12, 5'h02, 5'h0A, 5'h06, 5'h02, 5'h01};
   secl_host_model u_host (.pclk(pclk), .want(want), .pins(pins_in));
   secl_latches u_dut (.pclk(pclk), .presetn(presetn), .device_reset_n(device_reset_n),
      .pins_in(pins_in), .cfg_out(cfg_out), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // Outputs are taken mid-cycle, where they have settled
   always @(negedge pclk) cfg_seen = cfg_out;
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      es = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic run_rows();
      foreach (rows[i]) begin
         want <= secl_pins_t'(rows[i]);
         if (rows[i][4]) eb = rows[i][1:0];
         if (rows[i][3]) er = rows[i][0];
         if (rows[i][2]) eo = rows[i][1:0];
         repeat (5) @(posedge pclk);
         chk("cfg row", cfg_seen, {~eb, er, eo, 1'b1});
      end
   endtask : run_rows
   task automatic close_out();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Watchdog cuts a hung run short
   initial begin
      #20000;
      errors++;
      close_out();
   end
   // Main sequence: reset, table rows, device reset, register clear, bus errors
   initial begin
      {want, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      device_reset_n = 1'b1;
      repeat (10) @(posedge pclk);
      chk("reset cfg", cfg_seen, 32'h0000_0000);
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
      run_rows();
      device_reset_n <= 1'b0;
      repeat (5) @(posedge pclk);
      chk("device reset", cfg_seen, 32'h0000_0000);
      device_reset_n <= 1'b1;
      repeat (18) @(posedge pclk);
      chk("ready", cfg_seen, {~SECL_BIST_OFF, SECL_RXPWR_OFF, SECL_OE_OFF, 1'b1});
      run_rows();
      apb(1'b1, SECL_CTRL_OFS, 32'h0000_0001);
      repeat (4) @(posedge pclk);
      chk("ctrl clear", cfg_seen, 32'h0000_0000);
      apb(1'b0, SECL_STATUS_OFS, 32'h0000_0000);
      chk("status", rd & 32'h0000_07DF, 32'h0000_0043);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk("unmapped", {rd[30:0], es}, 32'h0000_0001);
      close_out();
   end
endmodule : testbench
